// ==== regs_consts.vh ====
`ifndef REGS_CONSTS_VH
`define REGS_CONSTS_VH

// register offsets
`define OFS_IDENT      12'h004
`define OFS_COPY_LIMIT 12'h00C
`define OFS_CHAIN      12'h080

// identification and interrupt control fields
`define ID_PRODUCT_HI  31
`define ID_PRODUCT_LO  16
`define ID_VERSION_HI  15
`define ID_VERSION_LO  12
`define IRQ_ENABLE_BIT 11
`define IRQ_LEVEL_HI   10
`define IRQ_LEVEL_LO   8
`define IRQ_VECTOR_HI  7
`define IRQ_VECTOR_LO  0
`define IRQ_CTRL_HI    11
`define IRQ_CTRL_RESET 12'h000

// copy channel limit fields
`define COPY_TOP_BIT   24
`define COPY_RESET     25'h000_0000
`define COPY_CHANNELS  32

// chain transfer setup fields
`define CHAIN_ADDR_HI  31
`define CHAIN_ADDR_LO  24
`define CHAIN_GA_HI    15
`define CHAIN_GA_LO    11
`define CHAIN_FIRST    2
`define CHAIN_LAST     1
`define CHAIN_ENABLE   0

// header and trailer word fields
`define WORD_GA_HI     31
`define WORD_GA_LO     27
`define WORD_COUNT_HI  17
`define WORD_COUNT_LO  0

// copy timing
`define CLOCK_NS       10
`define CHANNEL_NS     120
`define OVERHEAD_NS    260
`define CHANNEL_CYCLES ((`CHANNEL_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define OVERHEAD_CYCLES ((`OVERHEAD_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// ==== copy_sequencer.v ====
`timescale 1ns/1ps
`include "regs_consts.vh"

module copy_sequencer #(
	parameter CNT_W = 6
) (
	input  wire             clock_in,
	input  wire             reset_in,
	input  wire             start_in,
	input  wire [CNT_W-1:0] channels_in,
	output reg              busy_out,
	output reg              strobe_out,
	output reg  [4:0]       channel_out
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_OVH  = 3'b010;
	localparam [2:0] ST_CHAN = 3'b100;
	localparam integer OVH_N    = `OVERHEAD_CYCLES - 1;
	localparam integer CH_N     = `CHANNEL_CYCLES - 1;
	localparam [5:0]   OVH_LAST = OVH_N[5:0];
	localparam [5:0]   CH_LAST  = CH_N[5:0];

	reg [2:0]       state_q;
	reg [5:0]       tick_q;
	reg [CNT_W-1:0] left_q;

	// duration = overhead + channels * per-channel time
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state_q     <= ST_IDLE;
			tick_q      <= 6'h00;
			left_q      <= {CNT_W{1'b0}};
			busy_out    <= 1'b0;
			strobe_out  <= 1'b0;
			channel_out <= 5'h00;
		end else begin
			strobe_out <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (start_in) begin
					state_q  <= ST_OVH;
					tick_q   <= 6'h00;
					left_q   <= channels_in;
					busy_out <= 1'b1;
				end
			end
			ST_OVH: begin
				if (tick_q == OVH_LAST) begin
					tick_q <= 6'h00;
					if (left_q == {CNT_W{1'b0}}) begin
						state_q  <= ST_IDLE;
						busy_out <= 1'b0;
					end else begin
						state_q     <= ST_CHAN;
						strobe_out  <= 1'b1;
						channel_out <= 5'h00;
					end
				end else begin
					tick_q <= tick_q + 6'h01;
				end
			end
			ST_CHAN: begin
				// ascending channel order on channel_out
				if (tick_q == CH_LAST) begin
					tick_q <= 6'h00;
					left_q <= left_q - {{(CNT_W-1){1'b0}}, 1'b1};
					if (left_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						state_q  <= ST_IDLE;
						busy_out <= 1'b0;
					end else begin
						strobe_out  <= 1'b1;
						channel_out <= channel_out + 5'h01;
					end
				end else begin
					tick_q <= tick_q + 6'h01;
				end
			end
			default: begin
				state_q  <= ST_IDLE;
				busy_out <= 1'b0;
			end
			endcase
		end
	end
endmodule

// ==== scaler_regs.v ====
`timescale 1ns/1ps
`include "regs_consts.vh"

// Operation
// - upper sixteen bits return product number
// - bits fifteen to twelve return version
// - upper twenty bits read-only, low twelve writable
// - bit eleven enables bus interrupts
// - bits ten to eight pick level
// - vector bits drive data lines on acknowledge
// - request released when acknowledged
// - copy ascending, stop at lowest set bit
// - bits thirty-one to twenty-five follow bit 24
// - copy time linear in enabled channels
// - chain setup register readable and writable
// - chain address in bits thirty-one to 24
// - geographical address in bits fifteen to 11
// - interrupt needs source enable and bit eleven
// - header word carries geographical address only
// - trailer holds address and transfer count
module scaler_regs #(
	parameter [15:0] PRODUCT_ID = 16'h1234, // arbitrary value
	parameter [3:0]  VERSION_ID = 4'h1      // arbitrary value
) (
	input  wire        clock_in,
	input  wire        reset_in,
	input  wire [11:0] reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	input  wire        reg_write_in,
	input  wire        reg_read_in,
	output reg  [31:0] reg_rdata_out,
	output reg         reg_ack_out,
	input  wire [3:0]  irq_source_in,
	input  wire [3:0]  irq_source_enable_in,
	input  wire        iack_in,
	input  wire [2:0]  iack_level_in,
	output reg  [6:0]  irq_request_out,
	output reg  [7:0]  vector_out,
	output reg         vector_oe_out,
	input  wire        copy_start_in,
	output wire        copy_in_progress_out,
	output wire        copy_strobe_out,
	output wire [4:0]  copy_channel_out,
	input  wire [17:0] transfer_count_in,
	output reg  [7:0]  chain_addr_out,
	output reg  [4:0]  geo_addr_out,
	output reg         chain_enable_out,
	output reg         chain_first_out,
	output reg         chain_last_out,
	output reg  [31:0] header_word_out,
	output reg  [31:0] trailer_word_out
);
	reg [11:0] irq_ctrl_q;
	reg [24:0] copy_limit_q;
	reg [5:0]  channels_q;
	reg        pending_q;
	reg        armed_q;
	reg [2:0]  iack_sync_q;
	reg        iack_q;
	reg        iack_prev_q;
	reg [31:0] rdata_d;

	wire [2:0]  level     = irq_ctrl_q[`IRQ_LEVEL_HI:`IRQ_LEVEL_LO];
	wire [31:0] copy_full = {{7{copy_limit_q[`COPY_TOP_BIT]}}, copy_limit_q};
	wire        cond      = irq_ctrl_q[`IRQ_ENABLE_BIT] &
	                        (|(irq_source_in & irq_source_enable_in));
	wire        iack_rise = iack_q & ~iack_prev_q;
	wire        iack_mine = iack_rise & pending_q & (iack_level_in == level);

	// index of lowest set bit; none set means all channels
	function [5:0] lowest_set;
		input [31:0] bits;
		integer i;
		begin
			lowest_set = 6'd32;
			for (i = `COPY_CHANNELS - 1; i >= 0; i = i - 1) begin
				if (bits[i])
					lowest_set = i[5:0];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register writes and acknowledge

	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			irq_ctrl_q       <= `IRQ_CTRL_RESET;
			copy_limit_q     <= `COPY_RESET;
			chain_addr_out   <= 8'h00;
			geo_addr_out     <= 5'h00;
			chain_enable_out <= 1'b0;
			chain_first_out  <= 1'b0;
			chain_last_out   <= 1'b0;
			reg_ack_out      <= 1'b0;
			reg_rdata_out    <= 32'h0000_0000;
		end else begin
			reg_ack_out <= reg_write_in | reg_read_in;
			if (reg_read_in)
				reg_rdata_out <= rdata_d;
			if (reg_write_in) begin
				if (reg_addr_in == `OFS_IDENT) begin
					// id and version ignore writes
					irq_ctrl_q <= reg_wdata_in[`IRQ_CTRL_HI:0];
				end else if (reg_addr_in == `OFS_COPY_LIMIT) begin
					// upper bits are not stored
					copy_limit_q <= reg_wdata_in[`COPY_TOP_BIT:0];
				end else if (reg_addr_in == `OFS_CHAIN) begin
					chain_addr_out   <= reg_wdata_in[`CHAIN_ADDR_HI:`CHAIN_ADDR_LO];
					geo_addr_out     <= reg_wdata_in[`CHAIN_GA_HI:`CHAIN_GA_LO];
					chain_first_out  <= reg_wdata_in[`CHAIN_FIRST];
					chain_last_out   <= reg_wdata_in[`CHAIN_LAST];
					chain_enable_out <= reg_wdata_in[`CHAIN_ENABLE];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read decode

	always @* begin
		rdata_d = 32'h0000_0000;
		if (reg_addr_in == `OFS_IDENT) begin
			rdata_d[`ID_PRODUCT_HI:`ID_PRODUCT_LO] = PRODUCT_ID;
			rdata_d[`ID_VERSION_HI:`ID_VERSION_LO] = VERSION_ID;
			rdata_d[`IRQ_CTRL_HI:0]                = irq_ctrl_q;
		end else if (reg_addr_in == `OFS_CHAIN) begin
			// other bits stay zero
			rdata_d[`CHAIN_ADDR_HI:`CHAIN_ADDR_LO] = chain_addr_out;
			rdata_d[`CHAIN_GA_HI:`CHAIN_GA_LO]     = geo_addr_out;
			rdata_d[`CHAIN_FIRST]                  = chain_first_out;
			rdata_d[`CHAIN_LAST]                   = chain_last_out;
			rdata_d[`CHAIN_ENABLE]                 = chain_enable_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupter

	// acknowledge strobe is a bus pin: three stages, accept on agreement
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			iack_sync_q <= 3'b000;
			iack_q      <= 1'b0;
			iack_prev_q <= 1'b0;
		end else begin
			iack_sync_q <= {iack_sync_q[1:0], iack_in};
			if (iack_sync_q[1] == iack_sync_q[2])
				iack_q <= iack_sync_q[2];
			iack_prev_q <= iack_q;
		end
	end

	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			pending_q     <= 1'b0;
			armed_q       <= 1'b1;
			vector_out    <= 8'h00;
			vector_oe_out <= 1'b0;
		end else begin
			if (iack_mine) begin
				// release on acknowledge; re-arm once condition drops
				pending_q     <= 1'b0;
				armed_q       <= 1'b0;
				vector_out    <= irq_ctrl_q[`IRQ_VECTOR_HI:`IRQ_VECTOR_LO];
				vector_oe_out <= 1'b1;
			end else begin
				if (!iack_q)
					vector_oe_out <= 1'b0;
				if (!cond)
					armed_q <= 1'b1;
				// level zero is no level at all
				pending_q <= cond & (armed_q | pending_q) &
				             (level != 3'b000);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : gen_level
			always @(posedge clock_in or posedge reset_in) begin
				if (reset_in)
					irq_request_out[g] <= 1'b0;
				else
					irq_request_out[g] <= pending_q & ~iack_mine &
					                      (level == g + 1);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// copy loop and chain words

	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			channels_q       <= 6'd32;
			header_word_out  <= 32'h0000_0000;
			trailer_word_out <= 32'h0000_0000;
		end else begin
			channels_q <= lowest_set(copy_full);
			header_word_out <= {geo_addr_out, 27'h000_0000};
			trailer_word_out <= {geo_addr_out, 9'h000,
			                     transfer_count_in};
		end
	end

	copy_sequencer #(
		.CNT_W(6)
	) u_copy (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.start_in    (copy_start_in),
		.channels_in (channels_q),
		.busy_out    (copy_in_progress_out),
		.strobe_out  (copy_strobe_out),
		.channel_out (copy_channel_out)
	);
endmodule

// ==== regs_props.sv ====
`timescale 1ns/1ps
`include "regs_consts.vh"
module regs_props #(
	parameter [15:0] PRODUCT_ID = 16'h1234,
	parameter [3:0]  VERSION_ID = 4'h1
) (
	input wire        clock_in,
	input wire        reset_in,
	input wire [11:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire        reg_write_in,
	input wire        reg_read_in,
	input wire [31:0] reg_rdata_out,
	input wire        reg_ack_out,
	input wire [6:0]  irq_request_out,
	input wire [7:0]  vector_out,
	input wire        vector_oe_out,
	input wire        copy_in_progress_out,
	input wire        copy_strobe_out,
	input wire [4:0]  copy_channel_out,
	input wire [17:0] transfer_count_in,
	input wire [4:0]  geo_addr_out,
	input wire [31:0] header_word_out,
	input wire [31:0] trailer_word_out
);
	// shadow of the writable low bits, rebuilt from the bus traffic
	reg [11:0] ctrl_q;
	always @(posedge clock_in or posedge reset_in)
		if (reset_in)
			ctrl_q <= 12'h000;
		else if (reg_write_in && reg_addr_in == `OFS_IDENT)
			ctrl_q <= reg_wdata_in[11:0];
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	sequence first_s;
		##26 (copy_strobe_out && copy_channel_out == 5'h00);
	endsequence
	sequence gap_s;
		(!copy_strobe_out)[*8] ##4 (copy_strobe_out || !copy_in_progress_out);
	endsequence
	ack_follows_req_a: assert property ((reg_read_in || reg_write_in) |=> reg_ack_out) else $error("no ack after access");
	ident_fields_a: assert property (reg_read_in && reg_addr_in == `OFS_IDENT |=> reg_rdata_out == {PRODUCT_ID, VERSION_ID, $past(ctrl_q)}) else $error("ident read wrong");
	chain_unused_a: assert property (reg_read_in && reg_addr_in == `OFS_CHAIN |=> (reg_rdata_out & 32'h00ff_07f8) == 32'h0000_0000) else $error("chain spare bits set");
	irq_gate_a: assert property (|irq_request_out |-> ctrl_q[11] && irq_request_out == 7'h01 << (ctrl_q[10:8] - 3'h1)) else $error("bad request level");
	vector_drive_a: assert property (vector_oe_out |-> vector_out == ctrl_q[7:0]) else $error("vector wrong");
	ack_release_a: assert property ($rose(vector_oe_out) |-> irq_request_out == 7'h00) else $error("request kept");
	copy_first_a: assert property ($rose(copy_in_progress_out) |-> first_s) else $error("first copy late");
	strobe_gap_a: assert property (copy_strobe_out |=> gap_s) else $error("copy spacing");
	copy_order_a: assert property (copy_strobe_out |-> ##12 (!copy_strobe_out || copy_channel_out == $past(copy_channel_out, 12) + 5'h01)) else $error("copy order");
	header_word_a: assert property (header_word_out == {$past(geo_addr_out), 27'h000_0000}) else $error("header wrong");
	trailer_word_a: assert property (trailer_word_out == {$past(geo_addr_out), 9'h000, $past(transfer_count_in)}) else $error("trailer wrong");
endmodule
bind scaler_regs regs_props #(.PRODUCT_ID(PRODUCT_ID), .VERSION_ID(VERSION_ID)) regs_props_i (.*);

// ==== iack_master.sv ====
`timescale 1ns/1ps
module iack_master (
	input  wire       clock_in,
	input  wire [6:0] irq_request_in,
	input  wire [7:0] vector_in,
	input  wire       vector_oe_in,
	output reg        iack_out,
	output reg  [2:0] level_out,
	output reg  [7:0] vector_seen_out,
	output reg        seen_out
);
	integer k;
	initial begin
		iack_out = 1'b0;
		level_out = 3'h0;
		vector_seen_out = 8'h00;
		seen_out = 1'b0;
		forever begin
			@(negedge clock_in);
			seen_out = 1'b0;
			if (|irq_request_in) begin
				// slow handler some of the time
				repeat ($urandom % 4 + 2) @(negedge clock_in);
				for (k = 0; k < 7; k = k + 1)
					if (irq_request_in[k])
						level_out = k[2:0] + 3'h1;
				iack_out = 1'b1;
				k = 0;
				while (vector_oe_in !== 1'b1 && k < 20) begin
					@(negedge clock_in);
					k = k + 1;
				end
				vector_seen_out = vector_in;
				seen_out = 1'b1;
				iack_out = 1'b0;
				// level no longer qualified: show a changed value
				level_out = ~level_out;
			end
		end
	end
endmodule

// ==== scaler_regs_tb_top.sv ====
`timescale 1ns/1ps
`include "regs_consts.vh"
module scaler_regs_tb_top;
	localparam [15:0] PID = 16'h5a17; // arbitrary value
	localparam [3:0]  VID = 4'h3;     // arbitrary value
	reg         clock_in, reset_in, wr, rd, start;
	reg  [11:0] addr;
	reg  [31:0] wdata, d, held;
	reg  [3:0]  src, src_en;
	reg  [17:0] count;
	reg  [63:0] e;
	reg  [63:0] exp_q[$];
	reg  [7:0]  vec_q[$];
	wire [31:0] rdata;
	wire [6:0]  req;
	wire [7:0]  vec, vseen;
	wire [2:0]  lvl;
	wire        ack, iack, oe, busy, strobe, seen;
	wire [4:0]  chan, ga;
	wire [7:0]  caddr;
	wire [31:0] hdr, trl;
	wire        cen, cfirst, clast;
	wire [31:0] chain_seen = {caddr, 8'h00, ga, 8'h00, cfirst, clast, cen};
	integer     fails = 0, compares = 0, i, n, len, k;
	scaler_regs #(.PRODUCT_ID(PID), .VERSION_ID(VID)) scaler_regs_i (
		.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
		.reg_rdata_out(rdata), .reg_ack_out(ack), .irq_source_in(src),
		.irq_source_enable_in(src_en), .iack_in(iack), .iack_level_in(lvl),
		.irq_request_out(req), .vector_out(vec), .vector_oe_out(oe),
		.copy_start_in(start), .copy_in_progress_out(busy),
		.copy_strobe_out(strobe), .copy_channel_out(chan),
		.transfer_count_in(count), .chain_addr_out(caddr),
		.geo_addr_out(ga), .chain_enable_out(cen),
		.chain_first_out(cfirst), .chain_last_out(clast),
		.header_word_out(hdr), .trailer_word_out(trl));
	iack_master iack_master_i (.clock_in(clock_in), .irq_request_in(req),
		.vector_in(vec), .vector_oe_in(oe), .iack_out(iack),
		.level_out(lvl), .vector_seen_out(vseen), .seen_out(seen));
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	////////////////////////////////////////////////////////////////////////
	task check(input [31:0] got, input [31:0] want);
		compares = compares + 1;
		if (got !== want) begin
			fails = fails + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// m masks the read result; writes pass m = 0
	task acc(input w, input [11:0] a, input [31:0] v, input [31:0] m);
		@(negedge clock_in);
		wr = w;
		rd = !w;
		addr = a;
		wdata = v;
		// a write must leave the last read data standing
		exp_q.push_back(w ? {32'hffff_ffff, held} : {m, v});
		if (!w)
			held = v;
		@(negedge clock_in);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge clock_in)
		if (ack === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : 64'hffff_ffff_0bad_0bad;
			check(rdata & e[63:32], e[31:0] & e[63:32]);
		end
	always @(posedge clock_in)
		if (seen === 1'b1)
			check(vseen, vec_q.pop_front());
	initial begin
		#200000;
		fails = fails + 1;
		print_verdict;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_in, wr, rd, start} = 4'b1000;
		{addr, wdata, src, src_en, count} = 0;
		held = 32'h0000_0000;
		void'($urandom(35));
		repeat (8) @(posedge clock_in);
		@(negedge clock_in) reset_in = 1'b0;
		acc(0, `OFS_IDENT, {PID, VID, 12'h000}, '1);
		acc(0, `OFS_CHAIN, 0, '1);
		acc(0, `OFS_COPY_LIMIT, 0, '1);
		acc(0, 12'h040, 0, '1);
		$display("test reset values done");
		src_en = 4'hf;
		for (i = 1; i < 8; i = i + 1) begin
			d = $urandom;
			acc(1, `OFS_IDENT, {20'hf_ffff, 1'b1, i[2:0], d[7:0]}, 0);
			acc(0, `OFS_IDENT, {PID, VID, 1'b1, i[2:0], d[7:0]}, '1);
			vec_q.push_back(d[7:0]);
			src = 4'h1 << i[1:0];
			n = 0;
			while (seen !== 1'b1 && n < 100) begin
				@(posedge clock_in);
				n = n + 1;
			end
			check(n < 100, 1);
			@(negedge clock_in) src = 4'h0;
			repeat (8) @(negedge clock_in);
		end
		acc(1, `OFS_IDENT, 32'h0000_0355, 0);
		src = 4'h1;
		repeat (20) @(negedge clock_in);
		check(req, 0);
		src_en = 4'h0;
		acc(1, `OFS_IDENT, 32'h0000_0b55, 0);
		repeat (20) @(negedge clock_in);
		check(req, 0);
		{src, src_en} = 8'h0f;
		$display("test interrupts done");
		for (i = 0; i < 2; i = i + 1) begin
			d = $urandom;
			count = d[17:0];
			d = $urandom;
			d[2:0] = i ? 3'b011 : 3'b101;
			acc(1, `OFS_CHAIN, d, 0);
			acc(0, `OFS_CHAIN, d & 32'hff00_f807, '1);
			check(chain_seen, d & 32'hff00_f807);
			check(hdr, {d[15:11], 27'h000_0000});
			check(trl, {d[15:11], 9'h000, count});
		end
		$display("test chain setup done");
		for (i = 0; i < 4; i = i + 1) begin
			n = i == 0 ? 4 : i == 1 ? 24 : i == 2 ? 32 : $urandom % 23 + 1;
			d = i == 2 ? 32'h0200_0000 : 32'h0000_0001 << n;
			acc(1, `OFS_COPY_LIMIT, d, 0);
			repeat (2) @(negedge clock_in);
			start = 1'b1;
			@(negedge clock_in) start = 1'b0;
			// busy is already up at this edge
			len = (busy === 1'b1);
			k = 0;
			repeat (450) begin
				@(negedge clock_in);
				len = len + (busy === 1'b1);
				if (strobe === 1'b1) begin
					check(chan, k);
					k = k + 1;
				end
			end
			check(len, 26 + 12 * n);
			check(k, n);
		end
		$display("test copy cycle done");
		print_verdict;
	end
endmodule
